// [otp_regs.vh]
`ifndef OTP_REGS_VH
`define OTP_REGS_VH

// Register byte offsets on the APB slave.
`define OTP_ADDR_CMD        8'h00
`define OTP_ADDR_STATUS     8'h04
`define OTP_ADDR_VALID      8'h08
`define OTP_ADDR_RDATA      8'h0c

// Command word fields.
`define OTP_CMD_OP_LSB      0
`define OTP_CMD_OP_MSB      2
`define OTP_CMD_KEY_LSB     4
`define OTP_CMD_KEY_MSB     6
`define OTP_CMD_CODE_LSB    8
`define OTP_CMD_CODE_MSB    16

// Operation codes.
`define OTP_OP_NONE         3'h0
`define OTP_OP_TRY          3'h1
`define OTP_OP_BLOW         3'h2
`define OTP_OP_READ         3'h3
`define OTP_OP_LOCK         3'h4
`define OTP_OP_STOP         3'h5

// Status bit positions.
`define OTP_ST_BUSY         0
`define OTP_ST_ERR          1
`define OTP_ST_TRY          2
`define OTP_ST_GAIN_DONE    3
`define OTP_ST_ZERO_DONE    4
`define OTP_ST_LOCKED       5
`define OTP_ST_VALID        6

// Mode keys, parameter keys, the last fuse bit and the read bit count.
`define OTP_MODE_BLOW       9'h001
`define OTP_MODE_TRY        9'h002
`define OTP_MODE_READ       9'h003
`define OTP_KEY_GAIN        3'h1
`define OTP_KEY_ZERO        3'h2
`define OTP_KEY_FACTORY     3'h3
`define OTP_KEY_MARGIN      3'h4
`define OTP_BIT_LAST        9'h008
`define OTP_READ_BITS       9'h008

// Pin levels on the output pin driver.
`define OTP_LVL_LOW         2'h0
`define OTP_LVL_MID         2'h1
`define OTP_LVL_HIGH        2'h2

// Timing, in microseconds and in clock cycles, and the clock rate in MHz.
`define OTP_CLK_MHZ         250
`define OTP_T_LOW_US        20
`define OTP_T_ACTIVE_US     20
`define OTP_T_BLOW_US       100
`define OTP_T_PWR_US        1000
`define OTP_T_LOW_CYC       (`OTP_T_LOW_US * `OTP_CLK_MHZ)
`define OTP_T_ACTIVE_CYC    (`OTP_T_ACTIVE_US * `OTP_CLK_MHZ)
`define OTP_T_BLOW_CYC      (`OTP_T_BLOW_US * `OTP_CLK_MHZ)
`define OTP_T_PWR_CYC       (`OTP_T_PWR_US * `OTP_CLK_MHZ)

`endif

// [otp_pulse.v]
`timescale 1ns/1ps
`default_nettype none
`include "otp_regs.vh"

// Drives one pulse of the given level and width, then the idle level for the low time.
module otp_pulse (
   input  wire        mclk_i,
   input  wire        rst_i,
   input  wire        start_i,
   input  wire [1:0]  level_i,
   input  wire [31:0] width_i,
   input  wire [31:0] low_i,
   output reg  [1:0]  level_o,
   output reg         done_o
);

   localparam PH_IDLE = 2'h0;
   localparam PH_ACT  = 2'h1;
   localparam PH_LOW  = 2'h2;

   reg [1:0]  phase;
   reg [31:0] cnt;

   always @(posedge mclk_i) begin
      if (rst_i) begin
         phase   <= PH_IDLE;
         cnt     <= 32'h0;
         level_o <= `OTP_LVL_LOW;
         done_o  <= 1'b0;
      end else begin
         done_o <= 1'b0;
         case (phase)
            PH_IDLE: begin
               if (start_i) begin
                  phase   <= PH_ACT;
                  cnt     <= width_i;
                  level_o <= level_i;
               end
            end
            PH_ACT: begin
               if (cnt <= 32'h1) begin
                  phase   <= PH_LOW;
                  cnt     <= low_i;
                  level_o <= `OTP_LVL_LOW;
               end else begin
                  cnt <= cnt - 32'h1;
               end
            end
            PH_LOW: begin
               if (cnt <= 32'h1) begin
                  phase  <= PH_IDLE;
                  done_o <= 1'b1;
               end else begin
                  cnt <= cnt - 32'h1;
               end
            end
            default: begin
               phase   <= PH_IDLE;
               level_o <= `OTP_LVL_LOW;
            end
         endcase
      end
   end

endmodule // otp_pulse

`default_nettype wire

// [otp_fuse_prog.v]
`timescale 1ns/1ps
`default_nettype none
`include "otp_regs.vh"

module otp_fuse_prog #(
   parameter T_LOW_CYC    = `OTP_T_LOW_CYC,
   parameter T_ACTIVE_CYC = `OTP_T_ACTIVE_CYC,
   parameter T_BLOW_CYC   = `OTP_T_BLOW_CYC,
   parameter T_PWR_CYC    = `OTP_T_PWR_CYC
) (
   input  wire        mclk_i,
   input  wire        rst_i,
   input  wire        psel_i,
   input  wire        penable_i,
   input  wire        pwrite_i,
   input  wire [7:0]  paddr_i,
   input  wire [31:0] pwdata_i,
   output reg  [31:0] prdata_o,
   output wire        pready_o,
   output wire        pslverr_o,
   output wire [1:0]  pin_level_o,
   output reg         power_en_o,
   input  wire        supply_current_high_i
);

   localparam S_IDLE    = 4'h0;
   localparam S_PWRUP   = 4'h1;
   localparam S_ENTER   = 4'h2;
   localparam S_MODE    = 4'h3;
   localparam S_TOPARAM = 4'h4;
   localparam S_PARAM   = 4'h5;
   localparam S_TOADDR  = 4'h6;
   localparam S_BACK    = 4'h7;
   localparam S_CODE    = 4'h8;
   localparam S_BLOW    = 4'h9;
   localparam S_PWROFF  = 4'ha;

   localparam [31:0] LOW_CYC    = T_LOW_CYC;
   localparam [31:0] ACTIVE_CYC = T_ACTIVE_CYC;
   localparam [31:0] BLOW_CYC   = T_BLOW_CYC;
   localparam [31:0] PWR_CYC    = T_PWR_CYC;

   reg  [3:0]  state;
   reg  [2:0]  op;
   reg  [2:0]  pkey;
   reg  [8:0]  code;
   reg  [8:0]  cnt;
   reg         waiting;
   reg  [31:0] wait_cnt;
   reg         lock_phase;
   reg         try_active;
   reg         zero_last;
   reg         gain_done;
   reg         zero_done;
   reg         locked;
   reg         validated;
   reg         err;
   reg  [8:0]  rbits;
   reg  [3:0]  ridx;

   wire        wr_acc  = psel_i & penable_i & pwrite_i;
   wire        setup   = psel_i & ~penable_i;
   wire        mapped  = (paddr_i == `OTP_ADDR_CMD) | (paddr_i == `OTP_ADDR_STATUS) |
                         (paddr_i == `OTP_ADDR_VALID) | (paddr_i == `OTP_ADDR_RDATA);
   wire        cmd_wr  = wr_acc & (paddr_i == `OTP_ADDR_CMD);
   wire [2:0]  w_op    = pwdata_i[`OTP_CMD_OP_MSB:`OTP_CMD_OP_LSB];
   wire [2:0]  w_key   = pwdata_i[`OTP_CMD_KEY_MSB:`OTP_CMD_KEY_LSB];
   wire [8:0]  w_code  = pwdata_i[`OTP_CMD_CODE_MSB:`OTP_CMD_CODE_LSB];
   wire        idle    = (state == S_IDLE);
   wire        key_prg = (w_key == `OTP_KEY_GAIN) | (w_key == `OTP_KEY_ZERO) |
                         (w_key == `OTP_KEY_MARGIN);
   wire        key_any = key_prg | (w_key == `OTP_KEY_FACTORY);

   // Legality of each command as seen by the controller.
   wire ok_try  = key_prg & ~(try_active & zero_last);
   wire ok_blow = ~try_active & ~locked & key_prg & (w_code <= `OTP_BIT_LAST) &
                  ~((w_key == `OTP_KEY_MARGIN) & (w_code == `OTP_BIT_LAST)) &
                  ~((w_key == `OTP_KEY_ZERO) & ~gain_done);
   wire ok_read = ~try_active & key_any;
   wire ok_lock = ~try_active & ~locked & gain_done & zero_done & validated;
   reg  cmd_ok;

   always @* begin
      case (w_op)
         `OTP_OP_TRY:  cmd_ok = ok_try;
         `OTP_OP_BLOW: cmd_ok = ok_blow;
         `OTP_OP_READ: cmd_ok = ok_read;
         `OTP_OP_LOCK: cmd_ok = ok_lock;
         `OTP_OP_STOP: cmd_ok = 1'b1;
         default:      cmd_ok = 1'b0;
      endcase
   end

   wire        start_cmd = cmd_wr & idle & cmd_ok;
   wire        bad_cmd   = cmd_wr & ~(idle & cmd_ok);
   wire        pulse_st  = (state == S_ENTER) | (state == S_MODE) | (state == S_TOPARAM) |
                           (state == S_PARAM) | (state == S_TOADDR) | (state == S_BACK) |
                           (state == S_CODE) | (state == S_BLOW);
   wire        pl_start  = pulse_st & ~waiting & (cnt != 9'h000);
   wire        step_end  = pulse_st & ~waiting & (cnt == 9'h000);
   wire        pl_done;
   wire        is_mid    = (state == S_MODE) | (state == S_PARAM) | (state == S_CODE);
   wire [1:0]  pl_level  = is_mid ? `OTP_LVL_MID : `OTP_LVL_HIGH;
   wire [31:0] pl_width  = (state == S_BLOW) ? BLOW_CYC : ACTIVE_CYC;
   wire [8:0]  mode_key  = (op == `OTP_OP_TRY)  ? `OTP_MODE_TRY :
                           (op == `OTP_OP_READ) ? `OTP_MODE_READ : `OTP_MODE_BLOW;
   wire [8:0]  key_cnt   = {6'h00, pkey};
   wire [8:0]  code_cnt  = (op == `OTP_OP_READ) ? `OTP_READ_BITS :
                           (op == `OTP_OP_LOCK) ? (lock_phase ? 9'h000 : `OTP_BIT_LAST) :
                           code;

   otp_pulse u_pulse (
      .mclk_i  (mclk_i),
      .rst_i   (rst_i),
      .start_i (pl_start),
      .level_i (pl_level),
      .width_i (pl_width),
      .low_i   (LOW_CYC),
      .level_o (pin_level_o),
      .done_o  (pl_done)
   );

   always @(posedge mclk_i) begin
      if (rst_i) begin
         state      <= S_IDLE;
         op         <= `OTP_OP_NONE;
         pkey       <= 3'h0;
         code       <= 9'h000;
         cnt        <= 9'h000;
         waiting    <= 1'b0;
         wait_cnt   <= 32'h0;
         lock_phase <= 1'b0;
         try_active <= 1'b0;
         zero_last  <= 1'b0;
         gain_done  <= 1'b0;
         zero_done  <= 1'b0;
         locked     <= 1'b0;
         rbits      <= 9'h000;
         ridx       <= 4'h0;
         power_en_o <= 1'b0;
      end else begin
         if (pl_start) begin
            waiting <= 1'b1;
         end
         if (pl_done) begin
            waiting <= 1'b0;
            cnt     <= cnt - 9'h001;
            if (op == `OTP_OP_READ && state == S_TOADDR) begin
               rbits[0] <= supply_current_high_i;
               ridx     <= 4'h1;
            end
            if (op == `OTP_OP_READ && state == S_CODE) begin
               rbits[ridx] <= supply_current_high_i;
               ridx        <= ridx + 4'h1;
            end
         end
         case (state)
            S_IDLE: begin
               if (start_cmd) begin
                  op         <= w_op;
                  pkey       <= (w_op == `OTP_OP_LOCK) ? `OTP_KEY_MARGIN : w_key;
                  code       <= w_code;
                  lock_phase <= 1'b0;
                  if (w_op == `OTP_OP_STOP) begin
                     power_en_o <= 1'b0;
                     try_active <= 1'b0;
                     zero_last  <= 1'b0;
                     wait_cnt   <= PWR_CYC;
                     state      <= S_PWROFF;
                  end else if (w_op == `OTP_OP_TRY && try_active) begin
                     cnt   <= 9'h001;
                     state <= S_BACK;
                  end else begin
                     if (w_op == `OTP_OP_READ) begin
                        rbits <= 9'h000;
                     end
                     power_en_o <= 1'b1;
                     wait_cnt   <= PWR_CYC;
                     state      <= S_PWRUP;
                  end
               end
            end
            S_PWRUP: begin
               if (wait_cnt <= 32'h1) begin
                  cnt   <= 9'h001;
                  state <= S_ENTER;
               end else begin
                  wait_cnt <= wait_cnt - 32'h1;
               end
            end
            S_ENTER: begin
               if (step_end) begin
                  cnt   <= mode_key;
                  state <= S_MODE;
               end
            end
            S_MODE: begin
               if (step_end) begin
                  cnt   <= 9'h002;
                  state <= S_TOPARAM;
               end
            end
            S_TOPARAM, S_BACK: begin
               if (step_end) begin
                  cnt   <= key_cnt;
                  state <= S_PARAM;
               end
            end
            S_PARAM: begin
               if (step_end) begin
                  cnt   <= 9'h001;
                  state <= S_TOADDR;
               end
            end
            S_TOADDR: begin
               if (step_end) begin
                  cnt   <= code_cnt;
                  state <= S_CODE;
               end
            end
            S_CODE: begin
               if (step_end) begin
                  if (op == `OTP_OP_TRY) begin
                     try_active <= 1'b1;
                     zero_last  <= (pkey == `OTP_KEY_ZERO);
                     state      <= S_IDLE;
                  end else if (op == `OTP_OP_READ) begin
                     power_en_o <= 1'b0;
                     wait_cnt   <= PWR_CYC;
                     state      <= S_PWROFF;
                  end else begin
                     cnt   <= 9'h001;
                     state <= S_BLOW;
                  end
               end
            end
            S_BLOW: begin
               if (step_end) begin
                  // The pulse tail already held the low level for the low time.
                  power_en_o <= 1'b0;
                  wait_cnt   <= PWR_CYC;
                  state      <= S_PWROFF;
                  if (op == `OTP_OP_BLOW && pkey == `OTP_KEY_GAIN) begin
                     gain_done <= 1'b1;
                  end
                  if (op == `OTP_OP_BLOW && pkey == `OTP_KEY_ZERO) begin
                     zero_done <= 1'b1;
                  end
                  if (op == `OTP_OP_LOCK && lock_phase) begin
                     locked <= 1'b1;
                  end
               end
            end
            S_PWROFF: begin
               if (wait_cnt <= 32'h1) begin
                  if (op == `OTP_OP_LOCK && !lock_phase) begin
                     lock_phase <= 1'b1;
                     power_en_o <= 1'b1;
                     wait_cnt   <= PWR_CYC;
                     state      <= S_PWRUP;
                  end else begin
                     state <= S_IDLE;
                  end
               end else begin
                  wait_cnt <= wait_cnt - 32'h1;
               end
            end
            default: begin
               power_en_o <= 1'b0;
               state      <= S_IDLE;
            end
         endcase
      end
   end

   // Software registers; a new error wins over a clear in the same cycle.
   always @(posedge mclk_i) begin
      if (rst_i) begin
         err       <= 1'b0;
         validated <= 1'b0;
         prdata_o  <= 32'h0;
      end else begin
         if (bad_cmd) begin
            err <= 1'b1;
         end else if (wr_acc && paddr_i == `OTP_ADDR_STATUS && pwdata_i[`OTP_ST_ERR]) begin
            err <= 1'b0;
         end
         if (wr_acc && paddr_i == `OTP_ADDR_VALID) begin
            validated <= pwdata_i[0];
         end
         if (setup) begin
            case (paddr_i)
               `OTP_ADDR_STATUS: prdata_o <= {25'h0, validated, locked, zero_done, gain_done,
                                              try_active, err, ~idle};
               `OTP_ADDR_VALID:  prdata_o <= {31'h0, validated};
               `OTP_ADDR_RDATA:  prdata_o <= {23'h0, rbits};
               default:          prdata_o <= 32'h0;
            endcase
         end
      end
   end

   assign pready_o  = 1'b1;
   assign pslverr_o = psel_i & penable_i & ~mapped;

endmodule // otp_fuse_prog

`default_nettype wire

// [otp_fuse_prog_props.sv]
`timescale 1ns/1ps
`default_nettype none
module otp_fuse_prog_props #(
   parameter T_LOW_CYC    = 4,
   parameter T_ACTIVE_CYC = 4,
   parameter T_BLOW_CYC   = 8,
   parameter T_PWR_CYC    = 16
) (
   input wire        mclk_i,
   input wire        rst_i,
   input wire        psel_i,
   input wire        penable_i,
   input wire        pwrite_i,
   input wire [7:0]  paddr_i,
   input wire [31:0] pwdata_i,
   input wire [31:0] prdata_o,
   input wire        pready_o,
   input wire        pslverr_o,
   input wire [1:0]  pin_level_o,
   input wire        power_en_o,
   input wire        supply_current_high_i
);
   reg  [1:0]  lvl_q;
   reg  [31:0] run;
   wire        acc = psel_i && penable_i;
   wire        hit = paddr_i[7:4] == 4'h0 && paddr_i[1:0] == 2'h0;
   // Run holds how many edges the previous pin level lasted.
   always @(posedge mclk_i) begin
      if (rst_i) begin
         lvl_q <= 2'h0;
         run   <= 32'h0;
      end else begin
         lvl_q <= pin_level_o;
         run   <= (pin_level_o != lvl_q) ? 32'h1 : run + 32'h1;
      end
   end
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   ready_zero_wait_a: assert property (acc |-> pready_o)
      else $error("pready low in access phase");
   unmapped_slverr_a: assert property (acc |-> pslverr_o == !hit)
      else $error("pslverr does not match address decode");
   unmapped_zero_a: assert property (acc && !pwrite_i && !hit |-> prdata_o == 32'h0)
      else $error("unmapped read not zero");
   level_legal_a: assert property (pin_level_o != 2'h3)
      else $error("illegal pin level");
   pulse_width_a: assert property (lvl_q != 2'h0 && pin_level_o != lvl_q |->
      pin_level_o == 2'h0 && (run == T_ACTIVE_CYC || (lvl_q == 2'h2 && run == T_BLOW_CYC)))
      else $error("pulse width or return level wrong");
   low_gap_a: assert property (lvl_q == 2'h0 && pin_level_o != 2'h0 |-> run >= T_LOW_CYC)
      else $error("low gap between pulses too short");
   power_tail_a: assert property ($fell(power_en_o) |-> lvl_q == 2'h0 && run >= T_LOW_CYC - 1)
      else $error("power removed without low tail");
   no_pulse_off_a: assert property (!power_en_o |-> pin_level_o == 2'h0)
      else $error("pulse driven while unpowered");
   off_time_a: assert property ($fell(power_en_o) |-> !power_en_o [*8])
      else $error("power cycle too short");
   blow_cov_c: cover property (lvl_q == 2'h2 && pin_level_o == 2'h0 && run == T_BLOW_CYC);
   read_cov_c: cover property ($rose(supply_current_high_i));
   cycle_cov_c: cover property ($fell(power_en_o) ##[1:100] $rose(power_en_o));
endmodule // otp_fuse_prog_props
bind otp_fuse_prog otp_fuse_prog_props #(
   .T_LOW_CYC(T_LOW_CYC), .T_ACTIVE_CYC(T_ACTIVE_CYC), .T_BLOW_CYC(T_BLOW_CYC),
   .T_PWR_CYC(T_PWR_CYC)
) u_props (
   .mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
   .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
   .pready_o(pready_o), .pslverr_o(pslverr_o), .pin_level_o(pin_level_o),
   .power_en_o(power_en_o), .supply_current_high_i(supply_current_high_i)
);
`default_nettype wire

// [otp_dev_model.sv]
`timescale 1ns/1ps
`default_nettype none
module otp_dev_model #(
   parameter BLOW_MIN = 7,
   parameter TRY_MAX  = 127
) (
   input  wire       mclk_i,
   input  wire [1:0] pin_level_i,
   input  wire       power_en_i,
   output wire       supply_current_high_o
);
   reg [8:0] fuse [1:4];
   reg [8:0] trial [1:4];
   reg       final_lock;
   reg [2:0] st;
   reg [2:0] mkey;
   reg [2:0] pkey;
   reg [3:0] bsel;
   reg       hi_n;
   reg [1:0] lvl_q;
   integer   hcnt;
   integer   k;
   initial begin
      for (k = 1; k < 5; k = k + 1) fuse[k] = 9'h000;
      final_lock = 1'b0;
      lvl_q = 2'h0;
      hcnt = 0;
   end
   // The 250 uA read-entry step stays under the comparator threshold.
   assign supply_current_high_o = power_en_i && st == 3'd3 && mkey == 3'd3
                                  && fuse[pkey][bsel];
   always @(posedge mclk_i) begin
      lvl_q <= pin_level_i;
      hcnt <= (pin_level_i == lvl_q) ? hcnt + 1 : 1;
      if (power_en_i !== 1'b1) begin
         st <= 3'd0;
         mkey <= 3'd0;
         pkey <= 3'd0;
         bsel <= 4'd0;
         hi_n <= 1'b0;
         for (k = 1; k < 5; k = k + 1) trial[k] <= 9'h000;
      end else if (pin_level_i == 2'h0 && lvl_q == 2'h1) begin
         case (st)
            3'd1: mkey <= mkey + 3'd1;
            3'd2: pkey <= pkey + 3'd1;
            3'd3: begin
               if (mkey == 3'd2 && trial[pkey] < TRY_MAX)
                  trial[pkey] <= trial[pkey] + 9'd1;
               else if (mkey != 3'd2 && bsel < 4'd8)
                  bsel <= bsel + 4'd1;
            end
            default: ;
         endcase
      end else if (pin_level_i == 2'h0 && lvl_q == 2'h2) begin
         case (st)
            3'd0: st <= 3'd1;
            3'd1: begin
               if (hi_n) st <= 3'd2;
               hi_n <= 1'b1;
            end
            3'd2: begin
               st <= 3'd3;
               bsel <= 4'd0;
            end
            3'd3: begin
               if (mkey == 3'd2) begin
                  st <= 3'd2;
                  pkey <= 3'd0;
               end
               if (mkey == 3'd1) st <= 3'd4;
               if (mkey == 3'd1 && hcnt >= BLOW_MIN && !final_lock) begin
                  if (fuse[4][8]) final_lock <= 1'b1;
                  else fuse[pkey][bsel] <= 1'b1;
               end
            end
            default: ;
         endcase
      end
   end
endmodule // otp_dev_model
`default_nettype wire

// [otp_fuse_programming_fsm_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "otp_regs.vh"
module otp_fuse_programming_fsm_tb;
   logic        mclk_i;
   logic        rst_i;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [1:0]  pin_level;
   logic        power_en;
   wire         cur_hi;
   logic [31:0] rv;
   logic [31:0] exp_q[$];
   logic [31:0] msk_q[$];
   logic [8:0]  c1;
   logic [8:0]  c2;
   logic [8:0]  b0;
   logic [8:0]  b1;
   logic [8:0]  fexp;
   integer      error_cnt;
   integer      n_tests;
   otp_fuse_prog #(.T_LOW_CYC(4), .T_ACTIVE_CYC(4), .T_BLOW_CYC(8), .T_PWR_CYC(16)) uut (
      .mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .pin_level_o(pin_level), .power_en_o(power_en),
      .supply_current_high_i(cur_hi));
   otp_dev_model mdl (
      .mclk_i(mclk_i), .pin_level_i(pin_level), .power_en_i(power_en),
      .supply_current_high_o(cur_hi));
   task summarize;
      begin
         if (error_cnt == 0 && n_tests > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask
   task chk(input [31:0] e, input [31:0] m, input [31:0] g);
      begin
         n_tests = n_tests + 1;
         if ((g & m) !== (e & m)) begin
            error_cnt = error_cnt + 1;
            $display("Error at %0t: got %h expected %h mask %h", $time, g, e, m);
         end
      end
   endtask
   task apb(input [7:0] a, input w, input [31:0] d);
      integer n;
      begin
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge mclk_i);
         penable <= 1'b1;
         n = 0;
         @(posedge mclk_i);
         while (pready !== 1'b1 && n < 50) begin
            n = n + 1;
            @(posedge mclk_i);
         end
         rv = prdata;
         psel <= 1'b0;
         penable <= 1'b0;
         if (n >= 50) begin
            error_cnt = error_cnt + 1;
            summarize;
         end
         @(posedge mclk_i);
      end
   endtask
   task rd(input [7:0] a, input [31:0] e, input [31:0] m);
      begin
         exp_q.push_back(e);
         msk_q.push_back(m);
         apb(a, 1'b0, 32'h0);
      end
   endtask
   task cmd(input [2:0] op, input [2:0] key, input [8:0] code);
      integer n;
      begin
         apb(`OTP_ADDR_CMD, 1'b1, {15'h0, code, 1'b0, key, 1'b0, op});
         n = 0;
         rv = 32'h1;
         while (rv[`OTP_ST_BUSY] !== 1'b0 && n < 1000) begin
            rd(`OTP_ADDR_STATUS, 32'h0, 32'h0);
            n = n + 1;
         end
         if (n >= 1000) begin
            error_cnt = error_cnt + 1;
            summarize;
         end
      end
   endtask
   task err_clr;
      begin
         rd(`OTP_ADDR_STATUS, 32'h2, 32'h2);
         apb(`OTP_ADDR_STATUS, 1'b1, 32'h2);
         rd(`OTP_ADDR_STATUS, 32'h0, 32'h2);
      end
   endtask
   // Read results are compared in the order the reads were issued.
   always @(posedge mclk_i) begin
      if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
         if (msk_q[0] != 32'h0)
            chk(exp_q[0], msk_q[0], prdata);
         void'(exp_q.pop_front());
         void'(msk_q.pop_front());
      end
   end
   initial begin
      mclk_i = 1'b0;
      forever #2 mclk_i = ~mclk_i;
   end
   initial begin
      rst_i = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      error_cnt = 0;
      n_tests = 0;
      rv = $urandom(32'hd5ee);
      c1 = 9'd1 + $urandom % 20;
      c2 = 9'd1 + $urandom % 20;
      b1 = $urandom % 9;
      b0 = (b1 + 9'd1 + $urandom % 8) % 9;
      repeat (20) @(posedge mclk_i);
      rst_i <= 1'b0;
      @(posedge mclk_i);
      rd(`OTP_ADDR_STATUS, 32'h0, 32'h7f);
      rd(8'h10, 32'h0, 32'hffffffff);
      rd(`OTP_ADDR_CMD, 32'h0, 32'hffffffff);
      cmd(`OTP_OP_TRY, `OTP_KEY_GAIN, c1);
      chk({23'h0, c1}, 32'h1ff, {23'h0, mdl.trial[1]});
      rd(`OTP_ADDR_STATUS, 32'h4, 32'h4);
      cmd(`OTP_OP_TRY, `OTP_KEY_GAIN, 9'd200);
      chk(32'd127, 32'h1ff, {23'h0, mdl.trial[1]});
      cmd(`OTP_OP_TRY, `OTP_KEY_ZERO, c2);
      chk({23'h0, c2}, 32'h1ff, {23'h0, mdl.trial[2]});
      chk(32'd127, 32'h1ff, {23'h0, mdl.trial[1]});
      cmd(`OTP_OP_TRY, `OTP_KEY_GAIN, 9'd1);
      err_clr;
      cmd(`OTP_OP_STOP, 3'h0, 9'h0);
      chk(32'h0, 32'h1ff, {23'h0, mdl.trial[1]});
      cmd(`OTP_OP_BLOW, `OTP_KEY_ZERO, 9'd3);
      err_clr;
      cmd(`OTP_OP_BLOW, `OTP_KEY_GAIN, b1);
      cmd(`OTP_OP_BLOW, `OTP_KEY_GAIN, b0);
      fexp = (9'h1 << b1) | (9'h1 << b0);
      chk({23'h0, fexp}, 32'h1ff, {23'h0, mdl.fuse[1]});
      cmd(`OTP_OP_READ, `OTP_KEY_GAIN, 9'h0);
      rd(`OTP_ADDR_RDATA, {23'h0, fexp}, 32'h1ff);
      rd(`OTP_ADDR_STATUS, 32'h8, 32'h8);
      cmd(`OTP_OP_BLOW, `OTP_KEY_ZERO, 9'd3);
      cmd(`OTP_OP_LOCK, 3'h0, 9'h0);
      err_clr;
      apb(`OTP_ADDR_VALID, 1'b1, 32'h1);
      rd(`OTP_ADDR_VALID, 32'h1, 32'h1);
      cmd(`OTP_OP_LOCK, 3'h0, 9'h0);
      rd(`OTP_ADDR_STATUS, 32'h30, 32'h30);
      chk(32'h1, 32'h1, {31'h0, mdl.final_lock});
      cmd(`OTP_OP_BLOW, `OTP_KEY_GAIN, 9'd7);
      err_clr;
      cmd(`OTP_OP_READ, `OTP_KEY_GAIN, 9'h0);
      rd(`OTP_ADDR_RDATA, {23'h0, fexp}, 32'h1ff);
      cmd(`OTP_OP_READ, `OTP_KEY_ZERO, 9'h0);
      rd(`OTP_ADDR_RDATA, 32'h8, 32'h1ff);
      cmd(`OTP_OP_READ, `OTP_KEY_MARGIN, 9'h0);
      rd(`OTP_ADDR_RDATA, 32'h100, 32'h1ff);
      summarize;
   end
endmodule // otp_fuse_programming_fsm_tb
`default_nettype wire
